// >>> bench/cfg_far_side.sv
// Far side model: serial PROM, byte-wide EPROM and an upstream serial master.
// Assumes the bench gives the bit pattern and the slave bit count.
`timescale 1ns/10ps
module cfg_far_side (
  // Clock
  input wire logic        ref_clk,
  // Bench control
  input wire logic        slave_go,
  input wire logic [63:0] pattern,
  input wire logic [15:0] nbits,
  // Device pins
  input wire logic        config_clock_out,
  input wire logic        low_during_config,
  input wire logic        init_ready_flag,
  input wire logic [17:0] eprom_addr,
  input wire logic        eprom_addr_oe_n,
  output logic            config_clock_in,
  output logic            serial_data_in,
  output logic [7:0]      eprom_data
);
  logic [5:0] paddr = 6'h0;
  logic [7:0] tick  = 8'h0;
  logic       sdat  = 1'b0;
  logic       sdrv  = 1'b0;
  int         i;
  initial config_clock_in = 1'b0;
  always @(posedge ref_clk) tick <= tick + 8'h1;
  // PROM enable follows low_during_config, so its address restarts per load
  always @(posedge config_clock_out or posedge low_during_config) begin
    if (low_during_config) paddr <= 6'h0;
    else paddr <= paddr + 6'h1;
  end
  // Released lines wander so a stale value can never pass for data
  assign serial_data_in = sdrv ? sdat : (low_during_config ? tick[0] : pattern[paddr]);
  assign eprom_data = eprom_addr_oe_n ? tick : (eprom_addr[7:0] ^ eprom_addr[15:8] ^ 8'h3c);
  // Slave source, 200 ns clock that stands still between loads
  always begin
    wait (slave_go && init_ready_flag);
    #7;
    for (i = 0; i < nbits; i++) begin
      sdrv = 1'b1;
      sdat = pattern[i % 64];
      #50 config_clock_in = 1'b1;
      #50 config_clock_in = 1'b0;
      #100;
    end
    sdat = ~sdat;
    wait (!slave_go);
    sdrv = 1'b0;
  end
endmodule : cfg_far_side

// >>> bench/cfg_loader_asserts.sv
// Port checker for the configuration loader.
// Assumes it is bound into serial_parallel_config_loader.
`timescale 1ns/10ps
module cfg_loader_asserts
  import cfg_loader_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // Register port
  input wire logic [cfg_loader_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins
  input wire logic        config_clock_out,
  input wire logic        config_clock_oe_n,
  input wire logic        serial_data_out,
  input wire logic [17:0] eprom_addr,
  input wire logic        eprom_addr_oe_n,
  input wire logic        upper_address_oe_n,
  input wire logic        read_clock,
  input wire logic        low_during_config,
  input wire logic        init_ready_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic       aw22_ff;
  logic       seen_ff;
  logic       clk_q_ff;
  logic [7:0] cnt_ff;
  // First half period after start is skipped: in parallel modes it includes the read cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      aw22_ff  <= 1'b0;
      seen_ff  <= 1'b0;
      clk_q_ff <= 1'b0;
      cnt_ff   <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) aw22_ff <= reg_wdata[CTRL_AW22_BIT];
      seen_ff  <= !config_clock_oe_n && (seen_ff || config_clock_out != clk_q_ff);
      clk_q_ff <= config_clock_out;
      cnt_ff   <= (config_clock_out != clk_q_ff) ? 8'h01 : cnt_ff + 8'h01;
    end
  end
  a_busy_pins: assert property (low_during_config == !init_ready_flag)
    else $error("busy pins disagree");
  a_idle_hiz: assert property (!init_ready_flag |-> config_clock_oe_n && eprom_addr_oe_n)
    else $error("pins driven while idle");
  a_half_period: assert property (
    seen_ff && !config_clock_oe_n && config_clock_out != clk_q_ff |->
      cnt_ff == 8'(SLOW_HALF_CYC) || cnt_ff == 8'(FAST_HALF_CYC))
    else $error("config clock half period wrong");
  a_upper_hiz: assert property (!LOW_VOLTAGE && !aw22_ff |-> upper_address_oe_n)
    else $error("upper address driven");
  a_upper_drive: assert property (!eprom_addr_oe_n && (LOW_VOLTAGE || aw22_ff) |-> !upper_address_oe_n)
    else $error("upper address not driven");
  a_first_addr: assert property ($fell(eprom_addr_oe_n) |-> read_clock &&
    (eprom_addr == ADDR_UP_INIT[17:0] || eprom_addr == ADDR_DN_INIT[17:0]))
    else $error("bad first address");
  a_addr_step: assert property (
    $changed(eprom_addr) && !eprom_addr_oe_n && $past(!eprom_addr_oe_n) |-> !read_clock &&
      (eprom_addr == $past(eprom_addr) + 18'h1 || eprom_addr == $past(eprom_addr) - 18'h1))
    else $error("address step wrong");
  a_out_fall: assert property (
    $changed(serial_data_out) && !config_clock_oe_n && $past(!config_clock_oe_n) |->
      !config_clock_out && ($past(config_clock_out) || $past(config_clock_out, 2)))
    else $error("data out moved off a falling edge");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : cfg_loader_asserts

bind serial_parallel_config_loader cfg_loader_asserts #(.LOW_VOLTAGE(LOW_VOLTAGE)) chk_i (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_clock_out(config_clock_out),
  .config_clock_oe_n(config_clock_oe_n), .serial_data_out(serial_data_out), .eprom_addr(eprom_addr),
  .eprom_addr_oe_n(eprom_addr_oe_n), .upper_address_oe_n(upper_address_oe_n), .read_clock(read_clock),
  .low_during_config(low_during_config), .init_ready_flag(init_ready_flag)
);

// >>> bench/tb.sv
// Self-checking bench for the configuration loader.
// Assumes the far side model and the bound port checker.
`timescale 1ns/10ps
module tb;
  import cfg_loader_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slave_go = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, d;
  logic [2:0] mode_select = 3'h7;
  logic config_clock_in, config_clock_out, config_clock_oe_n, serial_data_in, serial_data_out;
  logic eprom_addr_oe_n, upper_address_oe_n, read_clock, low_during_config, init_ready_flag, config_done;
  logic [7:0] eprom_data;
  logic [17:0] eprom_addr;
  logic [3:0] upper_address_bits, upper_pin;
  // Board pull-downs decide the upper lines while the loader leaves them undriven
  assign upper_pin = upper_address_oe_n ? 4'h0 : upper_address_bits;
  logic [63:0] pattern = '0;
  logic [15:0] nbits = '0;
  logic obs, obs_q;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  int rises, lat, tot = 0, mode = 7, per, last_rise, idx;

  serial_parallel_config_loader #(.LOW_VOLTAGE(1'b0)) serial_parallel_config_loader_i (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_select(mode_select), .config_clock_in(config_clock_in),
    .config_clock_out(config_clock_out), .config_clock_oe_n(config_clock_oe_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .eprom_data(eprom_data),
    .eprom_addr(eprom_addr), .eprom_addr_oe_n(eprom_addr_oe_n), .upper_address_bits(upper_address_bits),
    .upper_address_oe_n(upper_address_oe_n), .read_clock(read_clock), .low_during_config(low_during_config),
    .init_ready_flag(init_ready_flag), .config_done(config_done));
  cfg_far_side cfg_far_side_i (
    .ref_clk(ref_clk), .slave_go(slave_go), .pattern(pattern), .nbits(nbits),
    .config_clock_out(config_clock_out), .low_during_config(low_during_config),
    .init_ready_flag(init_ready_flag), .eprom_addr(eprom_addr), .eprom_addr_oe_n(eprom_addr_oe_n),
    .config_clock_in(config_clock_in), .serial_data_in(serial_data_in), .eprom_data(eprom_data));

  initial forever #12.5 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Stream model: preamble 8 bits, own bits 8..23 held high, rest forwarded
  function automatic logic exp_bit(input int i);
    logic [17:0] a;
    logic [7:0] b;
    a = (mode == 4) ? 18'(i / 8) : 18'h3ffff - 18'(i / 8);
    b = a[7:0] ^ a[15:8] ^ 8'h3c;
    if (i >= 8 && i < 24) return 1'b1;
    if (mode == 4 || mode == 6) return b[i % 8];
    return pattern[i % 64];
  endfunction : exp_bit

  // Look at the first ref_clk fall after each config clock rise, where the next stage samples
  always @(negedge ref_clk) begin
    obs = (mode == 7) ? config_clock_in : config_clock_out;
    if (obs && !obs_q && tot > 0) begin
      rises++;
      per = cycles - last_rise;
      last_rise = cycles;
      idx = rises - 1 - lat;
      if (idx >= 0 && idx < tot) chk(32'(serial_data_out), 32'(exp_bit(idx)));
    end
    obs_q = obs;
  end

  task automatic run(input int m, input logic fast, input logic aw, input int n);
    mode = m;
    tot = 0;
    rises = 0;
    lat = (m == 0) ? 2 : 1;
    nbits = 16'(n);
    pattern <= {$urandom(), $urandom()};
    mode_select <= 3'(m);
    repeat (4) @(posedge ref_clk);
    wr(REG_TOT_LEN, 32'(n));
    wr(REG_CTRL, {29'h0, aw, fast, 1'b1});
    tot = n;
    #1;
    if (m == 4 || m == 6) chk(32'(eprom_addr), (m == 4) ? 32'h0 : 32'h3ffff);
    if (m == 4 || m == 6) chk(32'({upper_address_oe_n, upper_pin}), 32'({!aw, 4'h0}));
    slave_go = (m == 7);
    if (m == 4) begin
      repeat (100) @(posedge ref_clk);
      mode_select <= 3'h0;
    end
    for (int k = 0; k < 20000 && config_done !== 1'b1; k++) @(posedge ref_clk);
    chk(32'(config_done), 32'h1);
    tot = 0;
    slave_go = 1'b0;
    rd(REG_STATUS, d);
    chk(d & 32'hff, 32'((m << 4) | 8));
    rd(REG_BITCNT, d);
    chk(d, 32'(n));
    if (fast) chk(32'(per), 32'(2 * FAST_HALF_CYC));
  endtask : run

  initial begin
    void'($urandom(32'h1d33));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(REG_PRE_LEN, d);
    chk(d, PRE_LEN_RST);
    rd(REG_OWN_LEN, d);
    chk(d, OWN_LEN_RST);
    rd(REG_TOT_LEN, d);
    chk(d, TOT_LEN_RST);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, d);
    chk(d, 32'h0);
    rd(REG_STATUS, d);
    chk(d & 32'h8c, 32'h0);
    wr(REG_PRE_LEN, 32'h8);
    wr(REG_OWN_LEN, 32'h10);
    run(7, 1'b0, 1'b0, 40);
    run(0, 1'b0, 1'b0, 40);
    run(0, 1'b1, 1'b0, 160);
    run(4, 1'b0, 1'b1, 40);
    run(6, 1'b0, 1'b0, 40);
    mode_select <= 3'h3;
    repeat (4) @(posedge ref_clk);
    wr(REG_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    rd(REG_STATUS, d);
    chk(d & 32'h80, 32'h80);
    chk(32'(init_ready_flag), 32'h0);
    close_out();
  end
endmodule : tb

// >>> design/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : pin_sync

// >>> design/serial_parallel_config_loader.sv
// Configuration loader: slave serial, master serial, master parallel up/down.
// Assumes pins arrive asynchronously and the register port is on ref_clk.
//
// Summary of operation
// RULE1 - Outside party drives config clock and sets serial_data_in before each rise.
// RULE2 - Slave serial: serial_data_out updates on the falling edge after sampling.
// RULE3 - Preamble and bits beyond own length are forwarded on serial_data_out.
// RULE4 - Downstream device captures forwarded bit on the next rising edge.
// RULE5 - Mode 111 selects slave serial; open pins read as this mode.
// RULE6 - Master serial: device drives clock, samples PROM bit at following rise.
// RULE7 - Master serial forwarding is delayed 1.5 clock periods, changing on a fall.
// RULE8 - Fast rate option multiplies master clock by eight after a few bits; here the half period drops from 20 to 2 cycles, ten times.
// RULE9 - PROM chip enable comes from low_during_config or done.
// RULE10 - Mode 000 selects master serial with config clock as output.
// RULE11 - Parallel: present address, capture byte, then step the address.
// RULE12 - Bit zero of a captured byte appears on the fall 1.5 periods later.
// RULE13 - Mode 100 runs parallel up from address zero, incrementing.
// RULE14 - Mode 110 runs parallel down from 3ffff, decrementing.
// RULE15 - Upper address bits stay undriven unless 22 lines are requested.
// RULE16 - Low-voltage variant always drives all 22 address lines in parallel modes.
// RULE17 - Boards in parallel up mode pull the upper address lines down.
// RULE18 - First byte loads and clock starts at end of first read clock cycle.
// RULE19 - Source waits until init_ready_flag is high on every chained device.
// RULE20 - Captured bytes serialize least significant bit first, one per clock.
// RULE21 - Mode is sampled at start and held until configuration completes.
// RULE22 - Address counter is 18 bits, extended to 22 when upper lines active.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
module serial_parallel_config_loader
  import cfg_loader_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  // Register port
  input  wire logic [cfg_loader_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // Mode pins
  input  wire logic [2:0]                  mode_select,
  // Configuration clock pin
  input  wire logic                        config_clock_in,
  output logic                             config_clock_out,
  output logic                             config_clock_oe_n,
  // Serial data
  input  wire logic                        serial_data_in,
  output logic                             serial_data_out,
  // EPROM interface
  input  wire logic [7:0]                  eprom_data,
  output logic      [17:0]                 eprom_addr,
  output logic                             eprom_addr_oe_n,
  output logic      [3:0]                  upper_address_bits,
  output logic                             upper_address_oe_n,
  output logic                             read_clock,
  // Status pins
  output logic                             low_during_config,
  output logic                             init_ready_flag,
  output logic                             config_done
);

  import cfg_loader_pkg::*;

  if (SLOW_HALF_CYC > 31 || RCLK_CYC > 63) begin : g_div_check
    $error("clock divider counters too narrow for SLOW_HALF_NS");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [12:0] pins_s;

  pin_sync #(.WIDTH(13)) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({mode_select, config_clock_in, serial_data_in, eprom_data}),
    .sync_out (pins_s)
  );

  logic [2:0] mode_s;
  logic       config_clock_s;
  logic       din_s;
  logic [7:0] edata_s;
  assign mode_s  = pins_s[12:10];
  assign config_clock_s  = pins_s[9];
  assign din_s   = pins_s[8];
  assign edata_s = pins_s[7:0];

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic is_parallel(input logic [2:0] m);
    return (m == MODE_PAR_UP) || (m == MODE_PAR_DOWN);
  endfunction : is_parallel

  function automatic logic is_master(input logic [2:0] m);
    return (m == MODE_MASTER_SERIAL) || is_parallel(m);
  endfunction : is_master

  function automatic logic is_known(input logic [2:0] m);
    return is_master(m) || (m == MODE_SLAVE_SERIAL);
  endfunction : is_known

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    load_state_t state;
    logic [2:0]  mode;
    logic        config_clock;
    logic [4:0]  div;
    logic        config_clock_prev;
    logic        stage1;
    logic        stage2;
    logic        primed;
    logic        dout;
    logic [7:0]  byte_buf;
    logic [7:0]  shift;
    logic [2:0]  bidx;
    logic [2:0]  phase;
    logic [21:0] addr;
    logic [31:0] bit_cnt;
    logic        rclk;
    logic [5:0]  rcnt;
    logic        fast;
    logic        aw22;
    logic        bad_mode;
    logic [31:0] pre_len;
    logic [31:0] own_len;
    logic [31:0] tot_len;
    logic [31:0] rdata;
  } loader_t;

  loader_t cur_ff;
  loader_t nxt_cur;

  logic rise_ev;
  logic fall_ev;
  logic fwd;
  logic out_bit;
  logic wide;
  logic [4:0] half;

  always_comb begin
    nxt_cur = cur_ff;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    wide    = LOW_VOLTAGE || cur_ff.aw22;                              // [RULE15] [RULE16]
    half    = (cur_ff.fast && cur_ff.bit_cnt >= FAST_START_BITS) ?     // [RULE8]
              5'(FAST_HALF_CYC) : 5'(SLOW_HALF_CYC);
    // Own bits are swallowed; everything else goes down the chain
    fwd     = (cur_ff.bit_cnt < cur_ff.pre_len) ||
              (cur_ff.bit_cnt >= cur_ff.pre_len + cur_ff.own_len);    // [RULE3]
    out_bit = 1'b1;
    nxt_cur.config_clock_prev = config_clock_s;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          nxt_cur.fast = reg_wdata[CTRL_FAST_BIT];
          nxt_cur.aw22 = reg_wdata[CTRL_AW22_BIT];
        end
        REG_PRE_LEN: nxt_cur.pre_len = reg_wdata;
        REG_OWN_LEN: nxt_cur.own_len = reg_wdata;
        REG_TOT_LEN: nxt_cur.tot_len = reg_wdata;
        default: ;
      endcase
    end

    unique case (cur_ff.state)
      ST_IDLE, ST_DONE: begin
        if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT]) begin
          nxt_cur.mode     = mode_s;                                     // [RULE21]
          nxt_cur.bad_mode = !is_known(mode_s);
          nxt_cur.bit_cnt  = '0;
          nxt_cur.config_clock     = 1'b0;
          nxt_cur.div      = 5'(SLOW_HALF_CYC);
          nxt_cur.phase    = '0;
          nxt_cur.bidx     = '0;
          nxt_cur.dout     = 1'b1;
          nxt_cur.primed   = 1'b0;
          nxt_cur.addr     = (mode_s == MODE_PAR_DOWN) ? ADDR_DN_INIT : ADDR_UP_INIT; // [RULE13] [RULE14]
          nxt_cur.rcnt     = 6'(RCLK_CYC);
          if (is_parallel(mode_s)) begin
            nxt_cur.state = ST_RCLK;
            nxt_cur.rclk  = 1'b1;
          end else if (is_known(mode_s)) begin
            nxt_cur.state = ST_RUN;                                      // [RULE5] [RULE10]
          end
        end
      end

      ST_RCLK: begin
        // Clock stays still until the first read cycle has ended
        if (cur_ff.rcnt == 6'h01) begin
          nxt_cur.rclk     = 1'b0;
          nxt_cur.byte_buf = edata_s;                                    // [RULE18]
          nxt_cur.addr     = (cur_ff.mode == MODE_PAR_DOWN) ? cur_ff.addr - 22'h1 : cur_ff.addr + 22'h1;
          if (!wide) begin
            nxt_cur.addr = nxt_cur.addr & ADDR_MASK18;                   // [RULE22]
          end
          nxt_cur.state    = ST_RUN;
        end else begin
          nxt_cur.rcnt = cur_ff.rcnt - 6'h01;
        end
      end

      ST_RUN: begin
        if (is_master(cur_ff.mode)) begin
          if (cur_ff.div == 5'h01) begin
            nxt_cur.config_clock = !cur_ff.config_clock;                                 // [RULE6]
            nxt_cur.div  = half;
            rise_ev      = !cur_ff.config_clock;
            fall_ev      = cur_ff.config_clock;
          end else begin
            nxt_cur.div = cur_ff.div - 5'h01;
          end
        end else begin
          // Edges of the externally driven clock, from the synced copy
          rise_ev = config_clock_s && !cur_ff.config_clock_prev;                         // [RULE1]
          fall_ev = !config_clock_s && cur_ff.config_clock_prev;
        end

        if (rise_ev) begin
          nxt_cur.stage1 = din_s;                                        // [RULE6]
          nxt_cur.stage2 = cur_ff.stage1;
          if (is_parallel(cur_ff.mode)) begin
            nxt_cur.phase = cur_ff.phase + 3'h1;
            nxt_cur.rclk  = (cur_ff.phase >= 3'h3) && (cur_ff.phase != 3'h7);
            if (cur_ff.phase == 3'h0) begin
              nxt_cur.shift = cur_ff.byte_buf;
              nxt_cur.bidx  = '0;
            end
            if (cur_ff.phase == 3'h7) begin
              // Byte taken from the address shown, then address steps
              nxt_cur.byte_buf = edata_s;                                // [RULE11]
              nxt_cur.addr = (cur_ff.mode == MODE_PAR_DOWN) ? cur_ff.addr - 22'h1 : cur_ff.addr + 22'h1;
              if (!wide) begin
                nxt_cur.addr = nxt_cur.addr & ADDR_MASK18;               // [RULE22]
              end
            end
          end
        end

        if (fall_ev && cur_ff.mode == MODE_MASTER_SERIAL && !cur_ff.primed) begin
          // First fall precedes any bit in stage2; skipping it keeps bit_cnt on the bit shown
          nxt_cur.primed = 1'b1;                                         // [RULE7]
        end else if (fall_ev) begin
          unique case (cur_ff.mode)
            MODE_SLAVE_SERIAL:  out_bit = cur_ff.stage1;                 // [RULE2]
            MODE_MASTER_SERIAL: out_bit = cur_ff.stage2;                 // [RULE7]
            default:            out_bit = cur_ff.shift[cur_ff.bidx];     // [RULE12] [RULE20]
          endcase
          nxt_cur.bidx = cur_ff.bidx + 3'h1;
          // Held high while own bits pass, so downstream sees idle ones
          nxt_cur.dout    = fwd ? out_bit : 1'b1;                        // [RULE3] [RULE4]
          nxt_cur.bit_cnt = cur_ff.bit_cnt + 32'h1;
          if (cur_ff.bit_cnt + 32'h1 >= cur_ff.tot_len) begin
            nxt_cur.state = ST_DONE;
            nxt_cur.rclk  = 1'b0;
          end
        end
      end
    endcase

    // Register reads: data stand in the next cycle only
    nxt_cur.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:    nxt_cur.rdata = {29'h0, cur_ff.aw22, cur_ff.fast, 1'b0};
        REG_PRE_LEN: nxt_cur.rdata = cur_ff.pre_len;
        REG_OWN_LEN: nxt_cur.rdata = cur_ff.own_len;
        REG_TOT_LEN: nxt_cur.rdata = cur_ff.tot_len;
        REG_STATUS:  nxt_cur.rdata = {24'h0, cur_ff.bad_mode, cur_ff.mode, cur_ff.state, 2'h0};
        REG_BITCNT:  nxt_cur.rdata = cur_ff.bit_cnt;
        REG_ADDR:    nxt_cur.rdata = {10'h0, cur_ff.addr};
        default:     nxt_cur.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur_ff         <= '0;
      cur_ff.state   <= ST_IDLE;
      cur_ff.mode    <= MODE_SLAVE_SERIAL;
      cur_ff.dout    <= 1'b1;
      cur_ff.div     <= 5'(SLOW_HALF_CYC);
      cur_ff.pre_len <= PRE_LEN_RST;
      cur_ff.own_len <= OWN_LEN_RST;
      cur_ff.tot_len <= TOT_LEN_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  logic busy;
  assign busy = (cur_ff.state == ST_RCLK) || (cur_ff.state == ST_RUN);

  assign reg_rdata          = cur_ff.rdata;
  assign serial_data_out    = cur_ff.dout;
  assign config_clock_out   = cur_ff.config_clock;
  assign config_clock_oe_n  = !(busy && is_master(cur_ff.mode));        // [RULE10]
  assign eprom_addr         = cur_ff.addr[17:0];
  assign eprom_addr_oe_n    = !(busy && is_parallel(cur_ff.mode));
  assign upper_address_bits = cur_ff.addr[21:18];
  // Left floating otherwise so board pull-ups or pull-downs decide
  assign upper_address_oe_n = !(busy && is_parallel(cur_ff.mode) && wide); // [RULE15] [RULE16]
  assign read_clock         = cur_ff.rclk;
  assign low_during_config  = !busy;                                    // [RULE9]
  assign init_ready_flag    = busy;                                     // [RULE19]
  assign config_done        = (cur_ff.state == ST_DONE);                // [RULE9]

endmodule : serial_parallel_config_loader

// >>> inc/cfg_loader_pkg.sv
// Constants shared by the configuration loader and its register port.
// Assumes a 40 MHz ref_clk; all times are in ns and converted here.
package cfg_loader_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int REF_PERIOD_NS  = 25;
  localparam int SLOW_HALF_NS   = 500;
  localparam int FAST_FACTOR    = 8;
  localparam int FAST_HALF_NS   = SLOW_HALF_NS / FAST_FACTOR;
  // Both half periods round down, never below one cycle
  localparam int SLOW_HALF_CYC  = (SLOW_HALF_NS / REF_PERIOD_NS) < 1 ? 1 : SLOW_HALF_NS / REF_PERIOD_NS;
  localparam int FAST_HALF_CYC  = (FAST_HALF_NS / REF_PERIOD_NS) < 1 ? 1 : FAST_HALF_NS / REF_PERIOD_NS;
  localparam int RCLK_CYC       = 2 * SLOW_HALF_CYC;
  localparam int FAST_START_BITS = 64;

  // ------------------------------------------------------------------
  // Mode pin codes
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
  localparam logic [2:0] MODE_PAR_UP        = 3'h4;
  localparam logic [2:0] MODE_PAR_DOWN      = 3'h6;

  // ------------------------------------------------------------------
  // EPROM addressing
  // ------------------------------------------------------------------
  localparam int          ADDR_W_LOW   = 18;
  localparam int          ADDR_W_HIGH  = 22;
  localparam logic [21:0] ADDR_UP_INIT = 22'h000000;
  localparam logic [21:0] ADDR_DN_INIT = 22'h03ffff;
  localparam logic [21:0] ADDR_MASK18  = 22'h03ffff;

  // ------------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------------
  localparam int         REG_AW      = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_PRE_LEN = 8'h04;
  localparam logic [7:0] REG_OWN_LEN = 8'h08;
  localparam logic [7:0] REG_TOT_LEN = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_BITCNT  = 8'h14;
  localparam logic [7:0] REG_ADDR    = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FAST_BIT  = 1;
  localparam int CTRL_AW22_BIT  = 2;
  localparam logic [31:0] PRE_LEN_RST = 32'h00000020;
  localparam logic [31:0] OWN_LEN_RST = 32'h00000100;
  localparam logic [31:0] TOT_LEN_RST = 32'h00000200;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RCLK = 2'b01,
    ST_RUN  = 2'b11,
    ST_DONE = 2'b10
  } load_state_t;

endpackage : cfg_loader_pkg
